// *** rtl/ckgp_consts.svh ***
`ifndef CKGP_CONSTS_SVH
`define CKGP_CONSTS_SVH

// =============================================================
// Sizes
`define CKGP_NUM_NET 4
`define CKGP_NUM_EXT 2
`define CKGP_NUM_PLL 12
`define CKGP_NUM_PIN 16
`define CKGP_NUM_CORNER 4
`define CKGP_SEL_W 4
`define CKGP_SYNC_W 38

// =============================================================
// Clock pin index offset of each side
`define CKGP_OFS_LEFT 5'h00
`define CKGP_OFS_BOTTOM 5'h04
`define CKGP_OFS_RIGHT 5'h08
`define CKGP_OFS_TOP 5'h0c

// =============================================================
// PLL positions
`define CKGP_PLL_L1 0
`define CKGP_PLL_L2 1
`define CKGP_PLL_L3 2
`define CKGP_PLL_L4 3
`define CKGP_PLL_B1 4
`define CKGP_PLL_B2 5
`define CKGP_PLL_R1 6
`define CKGP_PLL_R2 7
`define CKGP_PLL_R3 8
`define CKGP_PLL_R4 9
`define CKGP_PLL_T1 10
`define CKGP_PLL_T2 11
`define CKGP_CORNER_L1 2'h0
`define CKGP_CORNER_L4 2'h1
`define CKGP_CORNER_R1 2'h2
`define CKGP_CORNER_R4 2'h3

// =============================================================
// Register map (byte addresses) and fields
`define CKGP_ADR_CTRL 8'h00
`define CKGP_ADR_STATUS 8'h04
`define CKGP_ADR_SEL_LO 8'h08
`define CKGP_ADR_SEL_HI 8'h0c
`define CKGP_CTRL_BYP_LSB 0
`define CKGP_CTRL_LOCK_BIT 8
`define CKGP_STAT_EXT_LSB 4
`define CKGP_STAT_NET_LSB 8
`define CKGP_STAT_XCLK_LSB 12
`define CKGP_SEL_PER_WORD 8
`define CKGP_SEL_PER_BYTE 2

// =============================================================
// Reset values
`define CKGP_EN_RST 1'b0
`define CKGP_BYP_RST 4'h0
`define CKGP_LOCK_RST 1'b0
`define CKGP_SEL_RST 4'h0
`define CKGP_WORD_RST 32'h0000_0000

`endif

// *** rtl/ckgp_pkg.sv ***
package ckgp_pkg;

	// Reference select codes of one PLL input multiplexer
	typedef enum logic [3:0] {
		CKGP_REF_PIN0 = 4'h0,
		CKGP_REF_PIN1 = 4'h1,
		CKGP_REF_PIN2 = 4'h2,
		CKGP_REF_PIN3 = 4'h3,
		CKGP_REF_NET0 = 4'h4,
		CKGP_REF_NET1 = 4'h5,
		CKGP_REF_NET2 = 4'h6,
		CKGP_REF_NET3 = 4'h7,
		CKGP_REF_ADJ = 4'h8,
		CKGP_REF_CORNER = 4'h9
	} ckgp_ref_sel_t;

	typedef logic [3:0] ckgp_sel_word_t;

endpackage

// *** rtl/ckgp_sync2.sv ***
`timescale 1ns/1ps
module ckgp_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // ckgp_sync2

// *** rtl/ckgp_gate_cell.sv ***
`timescale 1ns/1ps
`include "ckgp_consts.svh"
module ckgp_gate_cell (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic src_i,
	input wire logic en_i,
	input wire logic bypass_i,
	output logic en_state_o,
	output logic clk_o
);
	logic en_meta_r;
	logic en_live_r;
	logic src_prev_r;
	logic clk_out_r;
	logic en_pick;
	logic src_fall;

	// =============================================================
	// Enable path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_meta_r <= `CKGP_EN_RST;
		end else begin
			en_meta_r <= en_i;
		end
	end

	assign en_pick = bypass_i ? en_i : en_meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_prev_r <= `CKGP_EN_RST;
		end else begin
			src_prev_r <= src_i;
		end
	end

	assign src_fall = src_prev_r & ~src_i;

	// Enable only moves on a falling edge, so no pulse is ever cut short
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_live_r <= `CKGP_EN_RST;
		end else if (src_fall) begin
			en_live_r <= en_pick;
		end
	end

	// =============================================================
	// Gated output, parked low while disabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_out_r <= `CKGP_EN_RST;
		end else begin
			clk_out_r <= src_i & en_live_r;
		end
	end

	assign en_state_o = en_live_r;
	assign clk_o = clk_out_r;
endmodule // ckgp_gate_cell

// *** rtl/ckgp_top.sv ***
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ckgp_consts.svh"
// Notes on behaviour
// - Every network has its own enable gate, independent of any PLL.
// - External PLL clock output pins have their own enables, separate from the network enables.
// - The enable is taken on the falling edge of the gated clock.
// - A metastability register sits in the enable path, optionally bypassed.
// - Register or bypass path chosen by a static configuration bit.
// - External PLL clock pins always use the registered enable path.
// - Gating never touches PLL loop counters, so lock is kept.
// - Each PLL reference comes from a multiplexer of pins, networks, neighbour.
// - Multiplexer selects come only from configuration and stay fixed afterwards.
// - Non-corner pin index offset: left 0, bottom 4, right 8, top 12.
// - Each corner PLL has its own dedicated clock input pin.
// - Center pins of a side reach that side's corner PLLs directly.
// - Adjacent non-corner PLLs on one side have a direct cascade link.
// - At most twelve PLLs, named by side and position.
// - Core logic drives enables dynamically, per network, without any PLL.
module ckgp_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [`CKGP_NUM_NET-1:0] net_src_i,
	input wire logic [`CKGP_NUM_NET-1:0] net_en_i,
	output logic [`CKGP_NUM_NET-1:0] global_clock_network_o,
	input wire logic [`CKGP_NUM_EXT-1:0] ext_src_i,
	input wire logic [`CKGP_NUM_EXT-1:0] ext_en_i,
	output logic [`CKGP_NUM_EXT-1:0] external_pll_clock_pin_o,
	input wire logic [`CKGP_NUM_PIN-1:0] clk_pin_i,
	input wire logic [`CKGP_NUM_CORNER-1:0] corner_pll_dedicated_clock_pin_i,
	input wire logic [`CKGP_NUM_PLL-1:0] pll_cascade_i,
	output logic [`CKGP_NUM_PLL-1:0] pll_ref_o
);
	logic [`CKGP_SYNC_W-1:0] pins_raw;
	logic [`CKGP_SYNC_W-1:0] pins_s;
	logic [`CKGP_NUM_NET-1:0] net_src_s;
	logic [`CKGP_NUM_EXT-1:0] ext_src_s;
	logic [`CKGP_NUM_PIN-1:0] clk_pin_s;
	logic [`CKGP_NUM_CORNER-1:0] corner_s;
	logic [`CKGP_NUM_PLL-1:0] casc_s;
	logic [`CKGP_NUM_NET-1:0] net_clk;
	logic [`CKGP_NUM_NET-1:0] net_state;
	logic [`CKGP_NUM_EXT-1:0] ext_clk;
	logic [`CKGP_NUM_EXT-1:0] ext_state;
	logic [`CKGP_NUM_NET-1:0] bypass_r;
	logic lock_r;
	ckgp_pkg::ckgp_sel_word_t sel_r [`CKGP_NUM_PLL];
	logic [`CKGP_NUM_PLL-1:0] pll_ref_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_nxt;
	logic req;
	logic wr_ok;

	// =============================================================
	// Pin synchronisers
	// All incoming clocks are oversampled on clk_i, so they must be far slower than it
	assign pins_raw = {pll_cascade_i, corner_pll_dedicated_clock_pin_i, clk_pin_i, ext_src_i, net_src_i};

	ckgp_sync2 #(
		.W(`CKGP_SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	assign {casc_s, corner_s, clk_pin_s, ext_src_s, net_src_s} = pins_s;

	// =============================================================
	// Network and external pin gates
	genvar g;
	generate
		for (g = 0; g < `CKGP_NUM_NET; g++) begin : g_net
			ckgp_gate_cell u_gate (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.src_i(net_src_s[g]),
				.en_i(net_en_i[g]),
				.bypass_i(bypass_r[g]),
				.en_state_o(net_state[g]),
				.clk_o(net_clk[g])
			);
		end
		for (g = 0; g < `CKGP_NUM_EXT; g++) begin : g_ext
			// No bypass on the external pins
			ckgp_gate_cell u_gate (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.src_i(ext_src_s[g]),
				.en_i(ext_en_i[g]),
				.bypass_i(1'b0),
				.en_state_o(ext_state[g]),
				.clk_o(ext_clk[g])
			);
		end
	endgenerate

	assign global_clock_network_o = net_clk;
	assign external_pll_clock_pin_o = ext_clk;

	// =============================================================
	// PLL position helpers
	function automatic logic [4:0] side_ofs(input int p);
		case (p)
			`CKGP_PLL_L1, `CKGP_PLL_L2, `CKGP_PLL_L3, `CKGP_PLL_L4: side_ofs = `CKGP_OFS_LEFT;
			`CKGP_PLL_B1, `CKGP_PLL_B2: side_ofs = `CKGP_OFS_BOTTOM;
			`CKGP_PLL_R1, `CKGP_PLL_R2, `CKGP_PLL_R3, `CKGP_PLL_R4: side_ofs = `CKGP_OFS_RIGHT;
			default: side_ofs = `CKGP_OFS_TOP;
		endcase
	endfunction

	function automatic logic is_corner(input int p);
		is_corner = (p == `CKGP_PLL_L1) || (p == `CKGP_PLL_L4) || (p == `CKGP_PLL_R1) || (p == `CKGP_PLL_R4);
	endfunction

	function automatic logic [1:0] corner_idx(input int p);
		case (p)
			`CKGP_PLL_L1: corner_idx = `CKGP_CORNER_L1;
			`CKGP_PLL_L4: corner_idx = `CKGP_CORNER_L4;
			`CKGP_PLL_R1: corner_idx = `CKGP_CORNER_R1;
			default: corner_idx = `CKGP_CORNER_R4;
		endcase
	endfunction

	// Neighbour on the same side; corner PLLs have none and return themselves
	function automatic int partner(input int p);
		case (p)
			`CKGP_PLL_L2: partner = `CKGP_PLL_L3;
			`CKGP_PLL_L3: partner = `CKGP_PLL_L2;
			`CKGP_PLL_B1: partner = `CKGP_PLL_B2;
			`CKGP_PLL_B2: partner = `CKGP_PLL_B1;
			`CKGP_PLL_R2: partner = `CKGP_PLL_R3;
			`CKGP_PLL_R3: partner = `CKGP_PLL_R2;
			`CKGP_PLL_T1: partner = `CKGP_PLL_T2;
			`CKGP_PLL_T2: partner = `CKGP_PLL_T1;
			default: partner = p;
		endcase
	endfunction

	// =============================================================
	// PLL reference multiplexers
	// Only the reference is selected here; the loop counters are not in this block,
	// so no enable can disturb a locked loop
	generate
		for (g = 0; g < `CKGP_NUM_PLL; g++) begin : g_pll
			localparam logic [4:0] OFS = side_ofs(g);
			localparam logic CORNER = is_corner(g);
			localparam logic [1:0] CIDX = corner_idx(g);
			localparam int PART = partner(g);
			logic [4:0] pin_idx;
			logic pick;

			assign pin_idx = OFS + {3'h0, sel_r[g][1:0]};

			always_comb begin
				case (ckgp_pkg::ckgp_ref_sel_t'(sel_r[g]))
					ckgp_pkg::CKGP_REF_PIN0, ckgp_pkg::CKGP_REF_PIN1,
					ckgp_pkg::CKGP_REF_PIN2, ckgp_pkg::CKGP_REF_PIN3: begin
						pick = clk_pin_s[pin_idx[3:0]];
					end
					ckgp_pkg::CKGP_REF_NET0, ckgp_pkg::CKGP_REF_NET1,
					ckgp_pkg::CKGP_REF_NET2, ckgp_pkg::CKGP_REF_NET3: begin
						pick = net_clk[sel_r[g][1:0]];
					end
					ckgp_pkg::CKGP_REF_ADJ: begin
						pick = CORNER ? 1'b0 : casc_s[PART];
					end
					ckgp_pkg::CKGP_REF_CORNER: begin
						pick = CORNER ? corner_s[CIDX] : 1'b0;
					end
					default: begin
						pick = 1'b0;
					end
				endcase
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pll_ref_r[g] <= `CKGP_EN_RST;
				end else begin
					pll_ref_r[g] <= pick;
				end
			end
		end
	endgenerate

	assign pll_ref_o = pll_ref_r;

	// =============================================================
	// Wishbone slave
	// One wait state: ack rises the cycle after the request and drops the next
	assign req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr_ok = req & wb_we_i & ~lock_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= `CKGP_EN_RST;
		end else begin
			ack_r <= req;
		end
	end

	// Static configuration: writable until locked, frozen until the next reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bypass_r <= `CKGP_BYP_RST;
			lock_r <= `CKGP_LOCK_RST;
		end else if (wr_ok && (wb_adr_i == `CKGP_ADR_CTRL)) begin
			if (wb_sel_i[0]) begin
				bypass_r <= wb_dat_i[`CKGP_CTRL_BYP_LSB +: `CKGP_NUM_NET];
			end
			if (wb_sel_i[1]) begin
				lock_r <= wb_dat_i[`CKGP_CTRL_LOCK_BIT];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < `CKGP_NUM_PLL; p++) begin
				sel_r[p] <= `CKGP_SEL_RST;
			end
		end else if (wr_ok) begin
			for (int p = 0; p < `CKGP_NUM_PLL; p++) begin
				if ((wb_adr_i == ((p < `CKGP_SEL_PER_WORD) ? `CKGP_ADR_SEL_LO : `CKGP_ADR_SEL_HI)) &&
					wb_sel_i[(p % `CKGP_SEL_PER_WORD) / `CKGP_SEL_PER_BYTE]) begin
					sel_r[p] <= wb_dat_i[(p % `CKGP_SEL_PER_WORD) * `CKGP_SEL_W +: `CKGP_SEL_W];
				end
			end
		end
	end

	always_comb begin
		rd_nxt = `CKGP_WORD_RST;
		case (wb_adr_i)
			`CKGP_ADR_CTRL: begin
				rd_nxt[`CKGP_CTRL_BYP_LSB +: `CKGP_NUM_NET] = bypass_r;
				rd_nxt[`CKGP_CTRL_LOCK_BIT] = lock_r;
			end
			`CKGP_ADR_STATUS: begin
				rd_nxt[`CKGP_NUM_NET-1:0] = net_state;
				rd_nxt[`CKGP_STAT_EXT_LSB +: `CKGP_NUM_EXT] = ext_state;
				rd_nxt[`CKGP_STAT_NET_LSB +: `CKGP_NUM_NET] = net_clk;
				rd_nxt[`CKGP_STAT_XCLK_LSB +: `CKGP_NUM_EXT] = ext_clk;
			end
			`CKGP_ADR_SEL_LO: begin
				for (int p = 0; p < `CKGP_SEL_PER_WORD; p++) begin
					rd_nxt[p * `CKGP_SEL_W +: `CKGP_SEL_W] = sel_r[p];
				end
			end
			`CKGP_ADR_SEL_HI: begin
				for (int p = `CKGP_SEL_PER_WORD; p < `CKGP_NUM_PLL; p++) begin
					rd_nxt[(p - `CKGP_SEL_PER_WORD) * `CKGP_SEL_W +: `CKGP_SEL_W] = sel_r[p];
				end
			end
			default: begin
				rd_nxt = `CKGP_WORD_RST;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= `CKGP_WORD_RST;
		end else if (req) begin
			dat_r <= rd_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
endmodule // ckgp_top

// *** verif/ckgp_props.sv ***
`timescale 1ns/1ps
`include "ckgp_consts.svh"
module ckgp_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [`CKGP_NUM_NET-1:0] net_src_i,
	input wire logic [`CKGP_NUM_NET-1:0] net_en_i,
	input wire logic [`CKGP_NUM_NET-1:0] global_clock_network_o,
	input wire logic [`CKGP_NUM_EXT-1:0] ext_src_i,
	input wire logic [`CKGP_NUM_EXT-1:0] ext_en_i,
	input wire logic [`CKGP_NUM_EXT-1:0] external_pll_clock_pin_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [4:0] off_r, on_r, xoff_r;
	// =========================================
	// Enable age, saturating; 16 covers latch wait plus pipeline
	always_ff @(posedge clk_i) begin
		off_r <= (rst_i || net_en_i[0]) ? 5'h00 : off_r + {4'h0, off_r != 5'h1f};
		on_r <= (rst_i || !net_en_i[0]) ? 5'h00 : on_r + {4'h0, on_r != 5'h1f};
		xoff_r <= (rst_i || ext_en_i[0]) ? 5'h00 : xoff_r + {4'h0, xoff_r != 5'h1f};
	end
	// =========================================
	// Properties
	cfg_ack_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("config access not acked for exactly one cycle");
	unmapped_zero_a: assert property ((wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > 8'h0c)
		|=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	net_rise_a: assert property ($rose(global_clock_network_o[0])
		|-> $past(net_src_i[0], 3) && !$past(net_src_i[0], 4)) else $error("network pulse started mid-high");
	net_fall_a: assert property ($fell(global_clock_network_o[0])
		|-> !$past(net_src_i[0], 3) && $past(net_src_i[0], 4)) else $error("network pulse cut short");
	net_off_a: assert property (off_r >= 5'h10 |-> !global_clock_network_o[0])
		else $error("disabled network still toggles");
	net_on_a: assert property (on_r >= 5'h10 |-> global_clock_network_o[0] == $past(net_src_i[0], 3))
		else $error("enabled network does not follow its source");
	ext_off_a: assert property (xoff_r >= 5'h10 |-> !external_pll_clock_pin_o[0])
		else $error("disabled external pin still toggles");
	ext_rise_a: assert property ($rose(external_pll_clock_pin_o[0])
		|-> $past(ext_src_i[0], 3) && !$past(ext_src_i[0], 4)) else $error("external pulse started mid-high");
	cover property ($rose(global_clock_network_o[0]));
	cover property (off_r == 5'h10);
	cover property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0c);
endmodule // ckgp_props

bind ckgp_top ckgp_props i_ckgp_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .net_src_i(net_src_i),
	.net_en_i(net_en_i), .global_clock_network_o(global_clock_network_o), .ext_src_i(ext_src_i),
	.ext_en_i(ext_en_i), .external_pll_clock_pin_o(external_pll_clock_pin_o));

// *** verif/ckgp_core_model.sv ***
`timescale 1ns/1ps
`include "ckgp_consts.svh"
module ckgp_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [`CKGP_NUM_NET-1:0] net_req_i,
	input wire logic [`CKGP_NUM_EXT-1:0] ext_req_i,
	output logic [`CKGP_NUM_NET-1:0] net_src_o,
	output logic [`CKGP_NUM_EXT-1:0] ext_src_o,
	output logic [`CKGP_NUM_NET-1:0] net_en_o,
	output logic [`CKGP_NUM_EXT-1:0] ext_en_o
);
	logic [2:0] phase_r;
	// Sources at one eighth of clk_i, well under the oversampling limit
	always_ff @(posedge clk_i) begin
		phase_r <= rst_i ? 3'h0 : phase_r + 3'h1;
	end
	assign net_src_o = {`CKGP_NUM_NET{phase_r[2]}};
	assign ext_src_o = {`CKGP_NUM_EXT{~phase_r[2]}};
	// Enables move on any cycle, with no regard to the source phase
	always_ff @(posedge clk_i) begin
		net_en_o <= rst_i ? '0 : net_req_i;
		ext_en_o <= rst_i ? '0 : ext_req_i;
	end
endmodule // ckgp_core_model

// *** verif/ckgp_bench.sv ***
`timescale 1ns/1ps
`include "ckgp_consts.svh"
`define CKGP_CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
	$display("FAIL %0t got %h exp %h", $time, (got), (exp)); end end
module ckgp_bench;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0, net_req = 4'h0, net_src, net_en, gcn, corner = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [1:0] ext_req = 2'h0, ext_src, ext_en, xpin;
	logic [15:0] pins = 16'h0000;
	logic [11:0] pll_ref, casc = 12'h000;
	int fail_count = 0, comparisons = 0, cycles = 0, n_net, n_ext;
	ckgp_top i_ckgp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .net_src_i(net_src), .net_en_i(net_en), .global_clock_network_o(gcn),
		.ext_src_i(ext_src), .ext_en_i(ext_en), .external_pll_clock_pin_o(xpin), .clk_pin_i(pins),
		.corner_pll_dedicated_clock_pin_i(corner), .pll_cascade_i(casc), .pll_ref_o(pll_ref));
	ckgp_core_model i_ckgp_core_model (.clk_i(clk_i), .rst_i(rst_i), .net_req_i(net_req), .ext_req_i(ext_req),
		.net_src_o(net_src), .ext_src_o(ext_src), .net_en_o(net_en), .ext_en_o(ext_en));
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	// =========================================
	// Shared tasks
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 4'hf, 32'h0);
		`CKGP_CHECK(rd, exp)
	endtask
	// Counts high cycles over two source periods, network outputs into n_net and external pins into n_ext
	task automatic count_hi(input int wait_n);
		repeat (wait_n) @(posedge clk_i);
		n_net = 0;
		n_ext = 0;
		repeat (16) begin
			@(posedge clk_i);
			for (int j = 0; j < 4; j++) n_net += (gcn[j] === 1'b1);
			for (int j = 0; j < 2; j++) n_ext += (xpin[j] === 1'b1);
		end
	endtask
	// Cascade comes from its neighbour a corner asking for a neighbour gets 0
	function automatic logic [11:0] ref_exp(logic [15:0] p, logic [3:0] c, logic [11:0] k);
		return {p[15], p[14], p[10], k[7], p[11], c[2], p[6], p[5], 1'b0, p[3], p[0], c[0]};
	endfunction
	// =========================================
	// Scenarios
	task automatic t_reset();
		rd_chk(`CKGP_ADR_CTRL, `CKGP_WORD_RST);
		rd_chk(`CKGP_ADR_SEL_LO, `CKGP_WORD_RST);
		rd_chk(`CKGP_ADR_SEL_HI, `CKGP_WORD_RST);
	endtask
	task automatic t_gate(input logic [3:0] byp);
		wb(1'b1, `CKGP_ADR_CTRL, 4'h1, {28'h0, byp});
		rd_chk(`CKGP_ADR_CTRL, {28'h0, byp});
		net_req <= 4'hf;
		ext_req <= 2'h3;
		count_hi(21);
		`CKGP_CHECK(n_net, 32)
		`CKGP_CHECK(n_ext, 16)
		wb(1'b0, `CKGP_ADR_STATUS, 4'hf, 32'h0);
		`CKGP_CHECK(rd[5:0], 6'h3f)
		net_req <= 4'hd;
		ext_req <= 2'h1;
		count_hi(19);
		`CKGP_CHECK(n_net, 24)
		`CKGP_CHECK(n_ext, 8)
		net_req <= 4'h0;
		ext_req <= 2'h0;
		count_hi(23);
		`CKGP_CHECK(n_net + n_ext, 0)
	endtask
	task automatic t_sel();
		wb(1'b1, `CKGP_ADR_SEL_LO, 4'hf, 32'h3921_8309);
		wb(1'b1, `CKGP_ADR_SEL_HI, 4'hf, 32'h0000_3228);
		pins <= 16'ha5c3;
		corner <= 4'h9;
		casc <= 12'h080;
		repeat (6) @(posedge clk_i);
		`CKGP_CHECK(pll_ref, ref_exp(16'ha5c3, 4'h9, 12'h080))
		pins <= 16'h5a3c;
		corner <= 4'h6;
		casc <= 12'hf7f;
		repeat (6) @(posedge clk_i);
		`CKGP_CHECK(pll_ref, ref_exp(16'h5a3c, 4'h6, 12'hf7f))
		wb(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
		rd_chk(8'h10, 32'h0000_0000);
		rd_chk(`CKGP_ADR_SEL_HI, 32'h0000_3228);
	endtask
	// Lock freezes the configuration until the next reset
	task automatic t_lock();
		wb(1'b1, `CKGP_ADR_CTRL, 4'h2, 32'h0000_0100);
		wb(1'b1, `CKGP_ADR_SEL_LO, 4'hf, 32'h0000_0000);
		wb(1'b1, `CKGP_ADR_CTRL, 4'h3, 32'h0000_0000);
		rd_chk(`CKGP_ADR_SEL_LO, 32'h3921_8309);
		rd_chk(`CKGP_ADR_CTRL, 32'h0000_010f);
		`CKGP_CHECK(pll_ref, ref_exp(16'h5a3c, 4'h6, 12'hf7f))
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_gate(4'h0);
		t_gate(4'hf);
		t_sel();
		t_lock();
		stop_test();
	end
endmodule // ckgp_bench
